//--- verilog/gpp_pkg.sv
package gpp_pkg;

    localparam int          PIN_COUNT      = 16;
    localparam int          VEC_WIDTH      = 4;

    // Register byte offsets on the bus.
    localparam logic [7:0]  OFF_DIR        = 8'h00;
    localparam logic [7:0]  OFF_LEVEL      = 8'h04;
    localparam logic [7:0]  OFF_MASK       = 8'h08;
    localparam logic [7:0]  OFF_STATUS     = 8'h0C;
    localparam logic [7:0]  OFF_MODE       = 8'h10;
    localparam logic [7:0]  OFF_PEND       = 8'h14;

    // Field position of the shared pin configuration inside the global mode register.
    localparam int          MODE_CFG_BIT   = 0;

    // Reset values.
    localparam logic [15:0] RST_DIR        = 16'h0000;
    localparam logic [15:0] RST_LEVEL      = 16'h0000;
    localparam logic [15:0] RST_MASK       = 16'hFFFF;
    localparam logic        RST_MODE_CFG   = 1'b1;

    // Pins that take part in the port for each shared pin configuration.
    localparam logic [15:0] AVAIL_NARROW   = 16'h00FF;
    localparam logic [15:0] AVAIL_WIDE     = 16'hFFFF;

    typedef enum logic [0:0] {
        CFG_NARROW = 1'b0,
        CFG_WIDE   = 1'b1
    } pin_cfg_t;

endpackage

//--- verilog/pin_sync_edge.sv
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser followed by a history stage for change detection.
module pin_sync_edge #(
    parameter int W = 16
) (
    input  wire logic         i_clk_sys,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_d,
    output var  logic [W-1:0] o_level,
    output var  logic [W-1:0] o_change
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= i_d;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign o_level  = sync_q;
    assign o_change = sync_q ^ prev_q;

endmodule

`default_nettype wire

//--- verilog/general_purpose_pin_port.sv
// How it works
// R1: Sixteen pins, each direction set individually.
// R2: Shared pin configuration limits which pins exist.
// R3: Output pins driven from level register bits.
// R4: Level register read returns every pin's level.
// R5: Input pins are monitored continuously.
// R6: Any pin transition is a potential event.
// R7: Mask bit zero enables that pin's events.
// R8: Enabled events emit vectors into interrupt queue.
// R9: Sync pins, compare with previous sample.
`timescale 1ns/1ps
`default_nettype none

module general_purpose_pin_port
    import gpp_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [31:0] i_wb_dat,
    input  wire logic [3:0]  i_wb_sel,
    output var  logic [31:0] o_wb_dat,
    output var  logic        o_wb_ack,
    input  wire logic [15:0] i_pin_in,
    output var  logic [15:0] o_pin_out,
    output var  logic [15:0] o_pin_oe,
    output var  logic        o_irq,
    output var  logic        o_vec_valid,
    output var  logic [3:0]  o_vec_pin,
    input  wire logic        i_vec_ready
);

    logic        ack_q;
    logic [31:0] rdat_q;
    logic [15:0] dir_q;
    logic [15:0] level_q;
    logic [15:0] mask_q;
    logic [15:0] status_q;
    logic [15:0] pend_q;
    pin_cfg_t    cfg_q;
    logic [15:0] out_q;
    logic [15:0] oe_q;
    logic        irq_q;
    logic        vec_valid_q;
    logic [3:0]  vec_pin_q;

    logic        wb_hit;
    logic        wb_wr;
    logic [15:0] wmask;
    logic [15:0] avail;
    logic [15:0] pin_level;
    logic [15:0] pin_change;
    logic [15:0] events;
    logic [15:0] status_clr;
    logic        pick_any;
    logic [3:0]  pick_pin;
    logic [15:0] taken;
    logic        vec_load;
    logic [31:0] rdat_d;

    assign wb_hit = i_wb_cyc && i_wb_stb && !ack_q;
    // A write lands at the edge where the master samples ack, as a classic cycle expects.
    assign wb_wr  = i_wb_cyc && i_wb_stb && i_wb_we && ack_q;
    assign wmask  = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

    assign avail = (cfg_q == CFG_WIDE) ? AVAIL_WIDE : AVAIL_NARROW; // see R2

    pin_sync_edge #(
        .W (PIN_COUNT)
    ) u_sync (
        .i_clk_sys (i_clk_sys),
        .i_resetn  (i_resetn),
        .i_d       (i_pin_in),
        .o_level   (pin_level),
        .o_change  (pin_change)
    );

    // Output pins change too, so they are watched through the same pads as inputs.
    assign events = pin_change & avail; // see R6 see R9

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wb_hit;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            dir_q   <= RST_DIR;
            level_q <= RST_LEVEL;
            mask_q  <= RST_MASK;
            cfg_q   <= pin_cfg_t'(RST_MODE_CFG);
        end else if (wb_wr) begin
            case (i_wb_adr)
                OFF_DIR: begin
                    dir_q <= (dir_q & ~wmask) | (i_wb_dat[15:0] & wmask); // see R1
                end
                OFF_LEVEL: begin
                    level_q <= (level_q & ~wmask) | (i_wb_dat[15:0] & wmask);
                end
                OFF_MASK: begin
                    mask_q <= (mask_q & ~wmask) | (i_wb_dat[15:0] & wmask);
                end
                OFF_MODE: begin
                    if (i_wb_sel[0]) begin
                        cfg_q <= pin_cfg_t'(i_wb_dat[MODE_CFG_BIT]);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Unavailable pins stop being driven one cycle after the configuration change, whatever their direction bit says.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            oe_q  <= '0;
            out_q <= '0;
        end else begin
            oe_q  <= dir_q & avail; // see R1 see R2
            out_q <= level_q & avail; // see R3
        end
    end

    assign status_clr = (wb_wr && i_wb_adr == OFF_STATUS) ? (i_wb_dat[15:0] & wmask) : '0;

    // A new event wins over a clear in the same cycle.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~status_clr) | events;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(status_q & ~mask_q); // see R7
        end
    end

    // Scanning downward leaves the lowest pending pin as the pick.
    always_comb begin
        pick_any = 1'b0;
        pick_pin = '0;
        for (int i = PIN_COUNT - 1; i >= 0; i--) begin
            if (pend_q[i]) begin
                pick_any = 1'b1;
                pick_pin = 4'(i);
            end
        end
    end

    assign vec_load = pick_any && (!vec_valid_q || i_vec_ready);
    assign taken    = vec_load ? (16'h0001 << pick_pin) : '0;

    // Pending vectors are kept per pin, so a burst of edges on one pin
    // collapses into one vector; the queue never overflows this way.
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~taken) | (events & ~mask_q); // see R7 see R8
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            vec_valid_q <= 1'b0;
            vec_pin_q   <= '0;
        end else if (vec_load) begin
            vec_valid_q <= 1'b1; // see R8
            vec_pin_q   <= pick_pin;
        end else if (i_vec_ready) begin
            vec_valid_q <= 1'b0;
        end
    end

    always_comb begin
        rdat_d = '0;
        case (i_wb_adr)
            OFF_DIR:    rdat_d[15:0] = dir_q;
            OFF_LEVEL:  rdat_d[15:0] = pin_level & avail; // see R4 see R5
            OFF_MASK:   rdat_d[15:0] = mask_q;
            OFF_STATUS: rdat_d[15:0] = status_q;
            OFF_MODE:   rdat_d[MODE_CFG_BIT] = cfg_q;
            OFF_PEND:   rdat_d[15:0] = pend_q;
            default:    rdat_d = '0;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rdat_q <= '0;
        end else if (wb_hit && !i_wb_we) begin
            rdat_q <= rdat_d;
        end else begin
            rdat_q <= '0;
        end
    end

    assign o_wb_ack    = ack_q;
    assign o_wb_dat    = rdat_q;
    assign o_pin_out   = out_q;
    assign o_pin_oe    = oe_q;
    assign o_irq       = irq_q;
    assign o_vec_valid = vec_valid_q;
    assign o_vec_pin   = vec_pin_q;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    wb_ack_timing_a: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
        else $error("Bus answer is not a single cycle after the request.");

    dir_write_a: assert property ( // see R1
        wb_wr && i_wb_adr == OFF_DIR && i_wb_sel[0] |=> dir_q[7:0] == $past(i_wb_dat[7:0]))
        else $error("Direction write did not land.");

    narrow_cfg_a: assert property ( // see R2
        cfg_q == CFG_NARROW && $past(cfg_q == CFG_NARROW) |-> o_pin_oe[15:8] == 8'h00)
        else $error("Unavailable pin is driven.");

    pin_drive_a: assert property ( // see R3
        ##1 o_pin_out == $past(level_q & avail) && o_pin_oe == $past(dir_q & avail))
        else $error("Pin drive does not follow level and direction.");

    level_read_a: assert property ( // see R4
        wb_hit && !i_wb_we && i_wb_adr == OFF_LEVEL
        |=> o_wb_dat[15:0] == $past(pin_level & avail) && o_wb_dat[31:16] == 16'h0000)
        else $error("Level read returns wrong pin state.");

    pin_monitor_a: assert property ( // see R5
        $past(i_resetn, 2) |-> pin_level == $past(i_pin_in, 2))
        else $error("Pin level is not tracked through the synchroniser.");

    edge_status_a: assert property ( // see R6 see R9
        avail[0] && $past(pin_level[0]) != pin_level[0] |=> status_q[0])
        else $error("Pin transition did not set its status bit.");

    irq_mask_a: assert property ( // see R7
        ##1 o_irq == $past(|(status_q & ~mask_q)))
        else $error("Interrupt does not follow unmasked status.");

    masked_no_vec_a: assert property ( // see R7 see R8
        mask_q[0] && !pend_q[0] |=> !pend_q[0])
        else $error("Masked pin queued a vector.");

    vec_emit_a: assert property ( // see R8
        pend_q != 16'h0000 && !o_vec_valid |=> o_vec_valid)
        else $error("Pending event did not produce a vector.");

    vec_hold_a: assert property (
        o_vec_valid && !i_vec_ready |=> o_vec_valid && $stable(o_vec_pin))
        else $error("Vector changed before it was taken.");

    level_write_a: assert property ( // see R3
        wb_wr && i_wb_adr == OFF_LEVEL && i_wb_sel[0]
        |=> level_q[7:0] == $past(i_wb_dat[7:0]))
        else $error("Level register write did not land.");

    unavail_quiet_a: assert property ( // see R2
        cfg_q == CFG_NARROW |=> (status_q[15:8] & ~$past(status_q[15:8])) == 8'h00)
        else $error("Unavailable pin raised an event.");

    event_wins_a: assert property ( // see R6
        (events & status_clr) != 16'h0000
        |=> (status_q & $past(events & status_clr)) == $past(events & status_clr))
        else $error("Clear in the event cycle lost the event.");

    status_clear_a: assert property (
        status_clr != 16'h0000 |=> (status_q & $past(status_clr & ~events)) == 16'h0000)
        else $error("Written one did not clear its status bit.");

    unmasked_pend_a: assert property ( // see R7 see R8
        (events & ~mask_q) != 16'h0000
        |=> (pend_q & $past(events & ~mask_q)) == $past(events & ~mask_q))
        else $error("Unmasked event did not queue a vector.");

    vec_order_a: assert property ( // see R8
        vec_load
        |=> ($past(pend_q) & ((16'h0001 << o_vec_pin) - 16'h0001)) == 16'h0000
            && (($past(pend_q) >> o_vec_pin) & 16'h0001) == 16'h0001)
        else $error("Vector does not name the lowest pending pin.");

    read_idle_zero_a: assert property (
        !o_wb_ack |-> o_wb_dat == 32'h0000_0000)
        else $error("Read data shows outside the answer cycle.");

    cover_write_c: cover property (wb_wr && i_wb_adr == OFF_DIR);
    cover_event_c: cover property (events != 16'h0000 && status_clr != 16'h0000);
    cover_vector_c: cover property (o_vec_valid && i_vec_ready);
    cover_irq_c: cover property (!o_irq ##1 o_irq);
    cover_narrow_c: cover property (cfg_q == CFG_NARROW && events != 16'h0000);

endmodule

`default_nettype wire

//--- tb/pin_ckt.sv
`timescale 1ns/1ps
`default_nettype none

// Outside circuit on the pads: it yields a pad while the port drives it,
// so output pins read back the port's own level.
module pin_ckt (
    input  wire logic [15:0] i_out,
    input  wire logic [15:0] i_oe,
    input  wire logic [15:0] i_ext,
    output var  logic [15:0] o_pad
);
    always_comb begin
        o_pad = (i_oe & i_out) | (~i_oe & i_ext);
    end
endmodule

`default_nettype wire

//--- tb/general_purpose_pin_port_tb.sv
`timescale 1ns/1ps
`default_nettype none

module general_purpose_pin_port_tb;
    import gpp_pkg::*;

    logic        clk;
    logic        resetn;
    logic        cyc;
    logic        stb;
    logic        we;
    logic        rdy;
    logic [7:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [3:0]  sel;
    logic [3:0]  bsel;
    logic [15:0] ext;
    logic [15:0] pad;
    logic [15:0] pout;
    logic [15:0] poe;
    logic        ack;
    logic        irq;
    logic        vv;
    logic [3:0]  vpin;
    int          err_count;
    int          total_checks;

    general_purpose_pin_port uut (
        .i_clk_sys(clk), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(sel),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_pin_in(pad), .o_pin_out(pout),
        .o_pin_oe(poe), .o_irq(irq), .o_vec_valid(vv), .o_vec_pin(vpin),
        .i_vec_ready(rdy)
    );

    pin_ckt ckt (.i_out(pout), .i_oe(poe), .i_ext(ext), .o_pad(pad));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task summarize;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("Error %0t got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    task fail_wait;
        $display("Error %0t wait ran out", $time);
        err_count++;
        summarize;
    endtask

    // Request is held until ack is sampled high; data is taken at that edge.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        sel <= bsel;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        sel <= 4'h0;
        if (ack !== 1'b1) fail_wait;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0000_0000, q);
        chk(q, e);
    endtask

    task settle;
        repeat (6) @(posedge clk);
        #1;
    endtask

    task wait_vec;
        int n;
        n = 0;
        while (vv !== 1'b1 && n < 30) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (vv !== 1'b1) fail_wait;
    endtask

    // A vector is handed over at the one edge where ready meets valid.
    task take_vec;
        @(posedge clk);
        rdy <= 1'b1;
        @(posedge clk);
        rdy <= 1'b0;
        #1;
        chk(vv, 1'b0);
    endtask

    task t_reset;
        rd(OFF_DIR, 32'h0000_0000);
        rd(OFF_MASK, 32'h0000_ffff);
        rd(OFF_MODE, 32'h0000_0001);
        rd(OFF_PEND, 32'h0000_0000);
        rd(8'h18, 32'h0000_0000);
        bsel = 4'h2;
        wr(OFF_DIR, 32'h0000_ffff);
        bsel = 4'hf;
        rd(OFF_DIR, 32'h0000_ff00);
        wr(OFF_DIR, 32'h0000_0000);
    endtask

    // Reset in mid-run drops every output at once and restarts the pins.
    task t_rerst;
        @(posedge clk);
        resetn <= 1'b0;
        #1;
        chk(vv, 1'b0);
        chk(poe, 16'h0000);
        chk(pout, 16'h0000);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(OFF_MODE, 32'h0000_0001);
        rd(OFF_MASK, 32'h0000_ffff);
        settle;
        chk(irq, 1'b0);
        chk(vv, 1'b0);
        rd(OFF_STATUS, 32'h0000_ffff);
    endtask

    task t_drive;
        wr(OFF_DIR, 32'h0000_00f0);
        wr(OFF_LEVEL, 32'h0000_00a5);
        ext <= 16'h0003;
        settle;
        chk(poe, 16'h00f0);
        chk(pout, 16'h00a5);
        rd(OFF_LEVEL, 32'h0000_00a3);
    endtask

    task t_irq;
        wr(OFF_STATUS, 32'h0000_ffff);
        wr(OFF_MASK, 32'h0000_ffde);
        ext <= 16'h0002;
        wait_vec;
        chk(irq, 1'b1);
        chk(vpin, 4'h0);
        rd(OFF_STATUS, 32'h0000_0001);
        take_vec;
        wr(OFF_STATUS, 32'h0000_0001);
        settle;
        chk(irq, 1'b0);
        wr(OFF_LEVEL, 32'h0000_0085);
        wait_vec;
        chk(vpin, 4'h5);
        take_vec;
        ext <= 16'h0000;
        settle;
        chk(vv, 1'b0);
        rd(OFF_STATUS, 32'h0000_0022);
        wr(OFF_STATUS, 32'h0000_ffff);
        settle;
        chk(irq, 1'b0);
    endtask

    task t_narrow;
        wr(OFF_MODE, 32'h0000_0000);
        wr(OFF_DIR, 32'h0000_ffff);
        wr(OFF_LEVEL, 32'h0000_ffff);
        ext <= 16'hffff;
        settle;
        chk(poe, 16'h00ff);
        chk(pout, 16'h00ff);
        rd(OFF_LEVEL, 32'h0000_00ff);
    endtask

    initial begin
        cyc = 1'b0; stb = 1'b0; we = 1'b0; rdy = 1'b0; sel = 4'h0;
        bsel = 4'hf;
        adr = 8'h00; wdat = 32'h0000_0000; ext = 16'h0000; resetn = 1'b0;
        err_count = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_drive;
        t_irq;
        t_narrow;
        t_rerst;
        summarize;
    end
endmodule

`default_nettype wire
